// ==== cbm_far_model.sv ====
// far-side logic model that drives the channel b pins
`timescale 1ns/10ps
module cbm_far_model (
    input  wire logic [7:0] lowOut,
    input  wire logic [7:0] lowOe,
    input  wire logic [3:0] highOut,
    input  wire logic [3:0] highOe,
    input  wire logic [7:0] farLow,
    input  wire logic [7:0] farLowOe,
    input  wire logic [3:0] farHigh,
    output logic      [7:0] lowIn,
    output logic      [3:0] highIn
);
    // nobody driving: low pads carry pull-ups and read high; undriven high pins read farHigh
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            lowIn[i] = lowOe[i] ? lowOut[i] : (farLowOe[i] ? farLow[i] : 1'b1);
        end
        for (int i = 0; i < 4; i++) begin
            highIn[i] = highOe[i] ? highOut[i] : farHigh[i];
        end
    end
endmodule

// ==== cbm_mode_ctrl.sv ====
// main mode capture, run-time mode code decode and opto reset hold
`timescale 1ns/10ps
module cbm_mode_ctrl
    import cbm_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       cfgPresent,
    input  wire logic       cfgBlank,
    input  wire logic [1:0] cfgMode,
    input  wire logic [7:0] modeCode,
    input  wire logic       modeCodeValid,
    output cbm_main_t       mainMode,
    output cbm_fn_t         activeFn,
    output logic            optoHeld
);
    cbm_run_t runMode;

    // ------------------------------------------------------------
    // main mode from configuration
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mainMode <= MAIN_UART;
        end else if (!cfgPresent || cfgBlank) begin
            mainMode <= MAIN_UART; // R14
        end else begin
            case (cfgMode) // R3
                CFG_F245: mainMode <= MAIN_F245;
                CFG_FCPU: mainMode <= MAIN_FCPU;
                CFG_OPTO: mainMode <= MAIN_OPTO;
                default:  mainMode <= MAIN_UART;
            endcase
        end
    end

    // ------------------------------------------------------------
    // run-time code; unknown codes leave the mode as it is
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            runMode <= RUN_NONE;
        end else if (modeCodeValid) begin
            case (modeCode) // R1
                CODE_CLEAR: runMode <= RUN_NONE;
                CODE_ABB:   runMode <= (mainMode == MAIN_OPTO) ? runMode : RUN_ABB; // R8
                CODE_SSE:   runMode <= RUN_SSE;
                CODE_SBB:   runMode <= (mainMode == MAIN_OPTO) ? runMode : RUN_SBB; // R8
                CODE_BUS:   runMode <= RUN_BUS;
                default:    runMode <= runMode;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            optoHeld <= 1'b0;
        end else if (mainMode != MAIN_OPTO) begin
            optoHeld <= 1'b0;
        end else if (modeCodeValid && modeCode == CODE_OPTO) begin
            optoHeld <= 1'b1; // R2
        end else if (modeCodeValid && modeCode == CODE_CLEAR) begin
            optoHeld <= 1'b0; // R2
        end
    end

    // ------------------------------------------------------------
    // effective pin function
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            activeFn <= FN_UART;
        end else begin
            case (runMode) // R3
                RUN_SSE: activeFn <= FN_SSE;
                RUN_BUS: activeFn <= FN_BUS;
                RUN_ABB, RUN_SBB: begin
                    // guard again: config may turn to opto after the code
                    activeFn <= (mainMode == MAIN_OPTO) ? FN_OPTO : FN_BBANG; // R8
                end
                default: begin
                    case (mainMode)
                        MAIN_F245: activeFn <= FN_F245;
                        MAIN_FCPU: activeFn <= FN_FCPU;
                        MAIN_OPTO: activeFn <= FN_OPTO;
                        default:   activeFn <= FN_UART;
                    endcase
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence optoHoldReq;
        modeCodeValid && modeCode == CODE_OPTO && mainMode == MAIN_OPTO;
    endsequence
    sequence clearReq;
        modeCodeValid && modeCode == CODE_CLEAR;
    endsequence
    sequence sbbReq;
        modeCodeValid && modeCode == CODE_SBB && mainMode != MAIN_OPTO;
    endsequence

    a_opto_hold_set: assert property (optoHoldReq |=> optoHeld) // R2
        else $error("opto mode not held after hold code");
    a_opto_hold_free: assert property (clearReq |=> !optoHeld) // R2
        else $error("opto mode still held after clear code");
    a_sync_bb_entry: assert property (
        sbbReq ##1 (!modeCodeValid && mainMode != MAIN_OPTO) |=> activeFn == FN_BBANG) // R1
        else $error("bit-bang not active two cycles after its code");
    a_clear_to_main: assert property (clearReq ##1 !modeCodeValid |=>
        activeFn inside {FN_UART, FN_F245, FN_FCPU, FN_OPTO}) // R1
        else $error("run-time mode not cleared");
    a_bb_not_opto: assert property (activeFn == FN_BBANG |-> $past(mainMode) != MAIN_OPTO) // R8
        else $error("bit-bang active in opto mode");
    a_blank_is_uart: assert property ((!cfgPresent || cfgBlank) |=> mainMode == MAIN_UART) // R14
        else $error("blank configuration did not give serial mode");

endmodule

// ==== cbm_pin_mux.sv ====
// channel b pin function multiplexer, top level
`timescale 1ns/10ps
// How it works
// R1: mode code 0 clears, 1 async bang, 2 sync engine, 4 sync bang, 8 bus, 10 opto
// R2: in opto mode, code 10 holds opto in reset, code 0 releases it
// R3: uart, fifo, cpu fifo, opto from config; others only by mode code
// R4: sync serial engine lives on channel a; channel b pins stay idle
// R5: bus emulation: low port high address, high port cs, ale, rd, wr
// R6: opto uses low pins 0-3: data in, clock, data out, clear-to-send
// R7: fifo main modes put bang write on high pin 0, read on 1
// R8: no bit-bang on channel b while opto mode is enabled
// R9: uart main mode puts bang write on high pin 2, read on 3
// R10: wake pin works in uart, fifo, bang, opto; not in engine, bus, cpu
// R11: uart pin map: modem lines on low port, enable, suspend, leds high
// R12: fifo mode: low port data, high pins rx avail, tx space, rd, wr
// R13: cpu fifo mode: low port data, high pins cs, select, rd, wr
// R14: missing or blank config gives uart mode
module cbm_pin_mux
    import cbm_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic       cfgPresent,
    input  wire logic       cfgBlank,
    input  wire logic [1:0] cfgMode,
    input  wire logic [7:0] modeCode,
    input  wire logic       modeCodeValid,
    input  cbm_core_out_t   coreOut,
    output cbm_core_in_t    coreIn,
    input  wire logic [7:0] lowIn,
    output logic      [7:0] lowOut,
    output logic      [7:0] lowOe,
    input  wire logic [3:0] highIn,
    output logic      [3:0] highOut,
    output logic      [3:0] highOe,
    input  wire logic       sendNowWakeupB,
    output logic            wakeToCore,
    output cbm_fn_t         fnNow,
    output logic            optoResetHold
);
    cbm_main_t mainMode;
    cbm_fn_t   activeFn;
    logic      optoHeld;

    // ------------------------------------------------------------
    // mode control
    // ------------------------------------------------------------
    cbm_mode_ctrl u_mode (
        .ref_clk       (ref_clk),
        .reset_n       (reset_n),
        .cfgPresent    (cfgPresent),
        .cfgBlank      (cfgBlank),
        .cfgMode       (cfgMode),
        .modeCode      (modeCode),
        .modeCodeValid (modeCodeValid),
        .mainMode      (mainMode),
        .activeFn      (activeFn),
        .optoHeld      (optoHeld)
    );

    cbm_wake_gate u_wake (
        .ref_clk        (ref_clk),
        .reset_n        (reset_n),
        .activeFn       (activeFn),
        .sendNowWakeupB (sendNowWakeupB),
        .wakeToCore     (wakeToCore) // R10
    );

    // ------------------------------------------------------------
    // status
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fnNow         <= FN_UART;
            optoResetHold <= 1'b0;
        end else begin
            fnNow         <= activeFn;
            optoResetHold <= optoHeld; // R2
        end
    end

    // ------------------------------------------------------------
    // pin drive; all pins float during reset
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            lowOut  <= LOW_RESET;
            lowOe   <= OE_LOW_NONE;
            highOut <= HIGH_RESET;
            highOe  <= OE_HIGH_NONE;
        end else begin
            case (activeFn)
                FN_UART: begin
                    lowOut  <= {3'b000, coreOut.dtr_n, 1'b0, coreOut.rts_n,
                                1'b0, coreOut.serialOut}; // R11
                    lowOe   <= OE_LOW_UART; // R11
                    highOut <= {coreOut.transmitLed_n, coreOut.receiveLed_n,
                                coreOut.suspend_n, coreOut.transceiverDriveEnable}; // R11
                    highOe  <= OE_HIGH_ALL;
                end
                FN_F245: begin
                    lowOut  <= coreOut.fifoData; // R12
                    lowOe   <= coreOut.fifoDrive ? OE_LOW_ALL : OE_LOW_NONE;
                    highOut <= {2'b11, coreOut.transmitSpaceAvailable_n,
                                coreOut.receiveDataAvailable_n}; // R12
                    highOe  <= OE_HIGH_F245;
                end
                FN_FCPU: begin
                    // host owns every control line here
                    lowOut  <= coreOut.fifoData; // R13
                    lowOe   <= coreOut.fifoDrive ? OE_LOW_ALL : OE_LOW_NONE;
                    highOut <= HIGH_RESET;
                    highOe  <= OE_HIGH_NONE; // R13
                end
                FN_BBANG: begin
                    lowOut  <= coreOut.bbData;
                    lowOe   <= coreOut.bbDir;
                    highOut <= HIGH_RESET;
                    if (mainMode == MAIN_UART) begin
                        highOut[BB_WR_UART] <= coreOut.bbWrite_n; // R9
                        highOut[BB_RD_UART] <= coreOut.bbRead_n; // R9
                        highOe              <= OE_HIGH_BBU;
                    end else begin
                        highOut[BB_WR_FIFO] <= coreOut.bbWrite_n; // R7
                        highOut[BB_RD_FIFO] <= coreOut.bbRead_n; // R7
                        highOe              <= OE_HIGH_BBF;
                    end
                end
                FN_BUS: begin
                    lowOut  <= coreOut.addrHigh; // R5
                    lowOe   <= OE_LOW_ALL;
                    highOut <= {coreOut.busWr_n, coreOut.busRd_n,
                                coreOut.busAle, coreOut.busCs_n}; // R5
                    highOe  <= OE_HIGH_ALL;
                end
                FN_OPTO: begin
                    // a held link idles its outputs high so the far end sees no start
                    lowOut            <= LOW_RESET;
                    lowOut[OPTO_DOUT] <= optoHeld | coreOut.optoDataOut; // R6
                    lowOut[OPTO_CTS]  <= optoHeld | coreOut.optoClearToSend; // R6
                    lowOe             <= OE_LOW_OPTO;
                    highOut           <= HIGH_RESET;
                    highOe            <= OE_HIGH_NONE;
                end
                default: begin
                    // engine mode has no channel b pins
                    lowOut  <= LOW_RESET; // R4
                    lowOe   <= OE_LOW_NONE; // R4
                    highOut <= HIGH_RESET;
                    highOe  <= OE_HIGH_NONE; // R4
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // pin sampling towards the cores; unused lines read idle
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            coreIn <= CORE_IN_IDLE;
        end else begin
            coreIn <= CORE_IN_IDLE;
            case (activeFn)
                FN_UART: begin
                    coreIn.serialIn        <= lowIn[1]; // R11
                    coreIn.cts_n           <= lowIn[3];
                    coreIn.dsr_n           <= lowIn[5];
                    coreIn.carrierDetect_n <= lowIn[6];
                    coreIn.callAlert_n     <= lowIn[7]; // R11
                end
                FN_F245: begin
                    coreIn.fifoData <= lowIn; // R12
                    coreIn.fifoRd_n <= highIn[2];
                    coreIn.fifoWr   <= highIn[3]; // R12
                end
                FN_FCPU: begin
                    coreIn.fifoData       <= lowIn; // R13
                    coreIn.cpuCs_n        <= highIn[0];
                    coreIn.registerSelect <= highIn[1];
                    coreIn.cpuRd_n        <= highIn[2];
                    coreIn.cpuWr_n        <= highIn[3]; // R13
                end
                FN_BBANG: begin
                    coreIn.bbData <= lowIn;
                end
                FN_OPTO: begin
                    // inputs frozen idle while held so the engine sees no clock
                    if (!optoHeld) begin
                        coreIn.optoDataIn <= lowIn[OPTO_DIN]; // R6
                        coreIn.optoClock  <= lowIn[OPTO_CLK]; // R6
                    end
                end
                default: begin
                    coreIn <= CORE_IN_IDLE; // R4
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_bus_pin_map: assert property (activeFn == FN_BUS |=> // R5
        lowOut == $past(coreOut.addrHigh) && lowOe == OE_LOW_ALL &&
        highOut == {$past(coreOut.busWr_n), $past(coreOut.busRd_n),
                    $past(coreOut.busAle), $past(coreOut.busCs_n)})
        else $error("bus emulation pin map wrong");

    a_engine_idle: assert property (activeFn == FN_SSE |=> // R4
        lowOe == OE_LOW_NONE && highOe == OE_HIGH_NONE)
        else $error("channel b drives pins in engine mode");

    a_bb_fifo_strobe: assert property (activeFn == FN_BBANG && mainMode != MAIN_UART |=> // R7
        highOut[BB_WR_FIFO] == $past(coreOut.bbWrite_n) &&
        highOut[BB_RD_FIFO] == $past(coreOut.bbRead_n) && highOe == OE_HIGH_BBF)
        else $error("bang strobes misplaced for fifo main mode");

    a_bb_uart_strobe: assert property (activeFn == FN_BBANG && mainMode == MAIN_UART |=> // R9
        highOut[BB_WR_UART] == $past(coreOut.bbWrite_n) &&
        highOut[BB_RD_UART] == $past(coreOut.bbRead_n) && highOe == OE_HIGH_BBU)
        else $error("bang strobes misplaced for serial main mode");

    // release edge excluded: the flops there still saw reset
    a_uart_pin_map: assert property (reset_n && activeFn == FN_UART |=> // R11
        lowOe == OE_LOW_UART && lowOut[0] == $past(coreOut.serialOut) &&
        highOut[0] == $past(coreOut.transceiverDriveEnable) &&
        coreIn.callAlert_n == $past(lowIn[7]))
        else $error("serial pin map wrong");

    a_f245_pin_map: assert property (activeFn == FN_F245 |=> // R12
        highOe == OE_HIGH_F245 && highOut[0] == $past(coreOut.receiveDataAvailable_n) &&
        coreIn.fifoRd_n == $past(highIn[2]))
        else $error("fifo pin map wrong");

    a_cpu_pin_map: assert property (activeFn == FN_FCPU |=> // R13
        highOe == OE_HIGH_NONE && coreIn.registerSelect == $past(highIn[1]))
        else $error("cpu fifo pin map wrong");

    a_opto_pin_map: assert property (activeFn == FN_OPTO && !optoHeld |=> // R6
        lowOe == OE_LOW_OPTO && lowOut[OPTO_DOUT] == $past(coreOut.optoDataOut) &&
        coreIn.optoClock == $past(lowIn[OPTO_CLK]))
        else $error("opto pin map wrong");

    a_opto_held_idle: assert property (activeFn == FN_OPTO && optoHeld |=> // R2
        lowOut[OPTO_DOUT] && lowOut[OPTO_CTS] && coreIn.optoClock)
        else $error("held opto link not idle");

    a_fn_status: assert property (fnNow == $past(activeFn)) // R3
        else $error("function status does not follow the mode");

    a_hold_status: assert property (optoResetHold == $past(optoHeld)) // R2
        else $error("hold status does not follow the opto hold");

    a_fifo_data_oe: assert property (activeFn inside {FN_F245, FN_FCPU} |=> // R12
        lowOe == {8{$past(coreOut.fifoDrive)}})
        else $error("fifo data bus enable wrong");

endmodule

// ==== cbm_pkg.sv ====
// shared constants, modes and pin bundles for the channel b pin mux
package cbm_pkg;

    // ------------------------------------------------------------
    // run-time mode codes
    // ------------------------------------------------------------
    localparam logic [7:0] CODE_CLEAR = 8'h00;
    localparam logic [7:0] CODE_ABB   = 8'h01;
    localparam logic [7:0] CODE_SSE   = 8'h02;
    localparam logic [7:0] CODE_SBB   = 8'h04;
    localparam logic [7:0] CODE_BUS   = 8'h08;
    localparam logic [7:0] CODE_OPTO  = 8'h10;

    // ------------------------------------------------------------
    // nonvolatile main mode field
    // ------------------------------------------------------------
    localparam logic [1:0] CFG_UART = 2'h0;
    localparam logic [1:0] CFG_F245 = 2'h1;
    localparam logic [1:0] CFG_FCPU = 2'h2;
    localparam logic [1:0] CFG_OPTO = 2'h3;

    // ------------------------------------------------------------
    // pin positions
    // ------------------------------------------------------------
    localparam int BB_WR_FIFO = 0;
    localparam int BB_RD_FIFO = 1;
    localparam int BB_WR_UART = 2;
    localparam int BB_RD_UART = 3;
    localparam int OPTO_DIN   = 0;
    localparam int OPTO_CLK   = 1;
    localparam int OPTO_DOUT  = 2;
    localparam int OPTO_CTS   = 3;

    // ------------------------------------------------------------
    // output enable masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] OE_LOW_NONE  = 8'h00;
    localparam logic [7:0] OE_LOW_ALL   = 8'hFF;
    localparam logic [7:0] OE_LOW_UART  = 8'h15;
    localparam logic [7:0] OE_LOW_OPTO  = 8'h0C;
    localparam logic [3:0] OE_HIGH_NONE = 4'h0;
    localparam logic [3:0] OE_HIGH_ALL  = 4'hF;
    localparam logic [3:0] OE_HIGH_F245 = 4'h3;
    localparam logic [3:0] OE_HIGH_BBF  = 4'h3;
    localparam logic [3:0] OE_HIGH_BBU  = 4'hC;
    localparam logic [7:0] LOW_RESET    = 8'h00;
    localparam logic [3:0] HIGH_RESET   = 4'hF;

    typedef enum logic [1:0] {MAIN_UART, MAIN_F245, MAIN_FCPU, MAIN_OPTO} cbm_main_t;
    typedef enum logic [2:0] {RUN_NONE, RUN_ABB, RUN_SSE, RUN_SBB, RUN_BUS} cbm_run_t;
    typedef enum logic [2:0] {
        FN_UART, FN_F245, FN_FCPU, FN_OPTO, FN_BBANG, FN_SSE, FN_BUS
    } cbm_fn_t;

    // what the channel cores drive towards the pins
    typedef struct packed {
        logic       serialOut;
        logic       rts_n;
        logic       dtr_n;
        logic       transceiverDriveEnable;
        logic       suspend_n;
        logic       receiveLed_n;
        logic       transmitLed_n;
        logic [7:0] fifoData;
        logic       fifoDrive;
        logic       receiveDataAvailable_n;
        logic       transmitSpaceAvailable_n;
        logic [7:0] bbData;
        logic [7:0] bbDir;
        logic       bbWrite_n;
        logic       bbRead_n;
        logic [7:0] addrHigh;
        logic       busCs_n;
        logic       busAle;
        logic       busRd_n;
        logic       busWr_n;
        logic       optoDataOut;
        logic       optoClearToSend;
    } cbm_core_out_t;

    // what the pins deliver to the channel cores
    typedef struct packed {
        logic       serialIn;
        logic       cts_n;
        logic       dsr_n;
        logic       carrierDetect_n;
        logic       callAlert_n;
        logic [7:0] fifoData;
        logic       fifoRd_n;
        logic       fifoWr;
        logic       cpuCs_n;
        logic       registerSelect;
        logic       cpuRd_n;
        logic       cpuWr_n;
        logic [7:0] bbData;
        logic       optoDataIn;
        logic       optoClock;
    } cbm_core_in_t;

    localparam cbm_core_in_t CORE_IN_IDLE = '{
        serialIn: 1'b1, cts_n: 1'b1, dsr_n: 1'b1, carrierDetect_n: 1'b1,
        callAlert_n: 1'b1, fifoData: 8'h00, fifoRd_n: 1'b1, fifoWr: 1'b0,
        cpuCs_n: 1'b1, registerSelect: 1'b0, cpuRd_n: 1'b1, cpuWr_n: 1'b1,
        bbData: 8'h00, optoDataIn: 1'b1, optoClock: 1'b1
    };

endpackage

// ==== cbm_wake_gate.sv ====
// send-now / wake pin gating by pin function
`timescale 1ns/10ps
module cbm_wake_gate
    import cbm_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  cbm_fn_t   activeFn,
    input  wire logic sendNowWakeupB,
    output logic      wakeToCore
);
    logic wakeAvail;

    // pin is active low, so idle high when the mode hides it
    assign wakeAvail = (activeFn == FN_UART) || (activeFn == FN_F245) ||
                       (activeFn == FN_BBANG) || (activeFn == FN_OPTO); // R10

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wakeToCore <= 1'b1;
        end else begin
            wakeToCore <= wakeAvail ? sendNowWakeupB : 1'b1; // R10
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_wake_blocked: assert property (activeFn inside {FN_SSE, FN_BUS, FN_FCPU}
        |=> wakeToCore) // R10
        else $error("wake pin passed in a mode without it");
    a_wake_passed: assert property (reset_n && activeFn == FN_UART |=> // R10
        wakeToCore == $past(sendNowWakeupB))
        else $error("wake pin not passed in serial mode");

endmodule

// ==== channel_b_mode_pin_mux_tb.sv ====
// self-checking bench for the channel b pin mux
`timescale 1ns/10ps
module channel_b_mode_pin_mux_tb;
    import cbm_pkg::*;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic cfgPresent = 1'b0, cfgBlank = 1'b0, modeCodeValid = 1'b0, sendNowWakeupB = 1'b1;
    logic [1:0] cfgMode = 2'h0;
    logic [7:0] modeCode = 8'h00, lowIn, lowOut, lowOe, farLow = 8'h00, farLowOe = 8'h00;
    logic [3:0] highIn, highOut, highOe, farHigh = 4'hF;
    cbm_core_out_t coreOut = '0;
    cbm_core_in_t  coreIn;
    cbm_fn_t       fnNow;
    logic          wakeToCore, optoResetHold;
    int miscompares = 0, n_checks = 0, mainI = 0, runI = 0, hold = 0;
    logic [7:0] codes [7] = '{8'h01, 8'h04, 8'h02, 8'h08, 8'h00, 8'h10, 8'h00};

    always #50 ref_clk = ~ref_clk;

    cbm_pin_mux dut (.ref_clk(ref_clk), .reset_n(reset_n), .cfgPresent(cfgPresent),
        .cfgBlank(cfgBlank), .cfgMode(cfgMode), .modeCode(modeCode),
        .modeCodeValid(modeCodeValid), .coreOut(coreOut), .coreIn(coreIn), .lowIn(lowIn),
        .lowOut(lowOut), .lowOe(lowOe), .highIn(highIn), .highOut(highOut), .highOe(highOe),
        .sendNowWakeupB(sendNowWakeupB), .wakeToCore(wakeToCore), .fnNow(fnNow),
        .optoResetHold(optoResetHold));
    cbm_far_model far (.lowOut(lowOut), .lowOe(lowOe), .highOut(highOut), .highOe(highOe),
        .farLow(farLow), .farLowOe(farLowOe), .farHigh(farHigh), .lowIn(lowIn), .highIn(highIn));

    task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // compare the settled status, wake and selected pin outputs with what the bench model predicts
    task automatic verify();
        int fe;
        fe = (runI == 2) ? 5 : (runI == 3) ? 6 : (runI == 1 && mainI != 3) ? 4 : mainI;
        @(negedge ref_clk);
        check("fnNow", {9'h0, fnNow}, fe[11:0]);
        check("hold", {11'h0, optoResetHold}, hold[11:0]);
        check("wake", {11'h0, wakeToCore},
            {11'h0, sendNowWakeupB | (fe inside {2, 5, 6})});
        case (fe)
            0: begin
                check("uartOe", {highOe, lowOe}, 12'hF15);
                check("uartIo", {7'h0, coreIn.callAlert_n, highOut}, {7'h0,
                    farLow[7] | ~farLowOe[7], coreOut.transmitLed_n, coreOut.receiveLed_n,
                    coreOut.suspend_n, coreOut.transceiverDriveEnable});
            end
            1: begin
                check("fifoOe", {highOe, lowOe}, {4'h3, {8{coreOut.fifoDrive}}});
                check("fifoIo", {9'h0, coreIn.fifoRd_n, highOut[1:0]}, {9'h0,
                    farHigh[2], coreOut.transmitSpaceAvailable_n,
                    coreOut.receiveDataAvailable_n});
            end
            2: check("cpuOe", {highOe, lowOe}, {4'h0, {8{coreOut.fifoDrive}}});
            3: begin
                check("optoOe", {highOe, lowOe}, 12'h00C);
                check("optoIo", {9'h0, coreIn.optoClock, lowOut[3:2]}, {9'h0,
                    hold[0] | farLow[1], hold[0] | coreOut.optoClearToSend,
                    hold[0] | coreOut.optoDataOut});
            end
            4: begin
                check("bangOe", {highOe, lowOe},
                    {(mainI == 0) ? 4'hC : 4'h3, coreOut.bbDir});
                check("bangOut", {highOut, lowOut}, {(mainI == 0) ?
                    {coreOut.bbRead_n, coreOut.bbWrite_n, 2'b11} :
                    {2'b11, coreOut.bbRead_n, coreOut.bbWrite_n}, coreOut.bbData});
            end
            5: check("engineOe", {highOe, lowOe}, 12'h000);
            default: check("busOut", {highOe, lowOut}, {4'hF, coreOut.addrHigh});
        endcase
        // back on a rising edge so the next drive lands there
        @(posedge ref_clk);
    endtask

    task automatic send_code(input logic [7:0] c);
        @(posedge ref_clk);
        modeCode <= c;
        modeCodeValid <= 1'b1;
        @(posedge ref_clk);
        modeCodeValid <= 1'b0;
        repeat (3) @(posedge ref_clk);
        case (c)
            8'h00: begin runI = 0; hold = 0; end
            8'h01, 8'h04: if (mainI != 3) runI = 1;
            8'h02: runI = 2;
            8'h08: runI = 3;
            8'h10: if (mainI == 3) hold = 1;
            default: ;
        endcase
        verify();
    endtask

    initial begin
        repeat (5000) @(posedge ref_clk);
        miscompares++;
        finish_test();
    end

    initial begin
        void'($urandom(98));
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        verify();
        $display("no config store done");
        // blank store must not take the programmed main mode
        cfgPresent <= 1'b1;
        cfgBlank <= 1'b1;
        cfgMode <= 2'h1;
        repeat (4) @(posedge ref_clk);
        verify();
        $display("blank config store done");
        for (int m = 0; m < 4; m++) begin
            @(posedge ref_clk);
            cfgBlank <= 1'b0;
            cfgMode <= m[1:0];
            coreOut <= $bits(cbm_core_out_t)'({$urandom, $urandom});
            sendNowWakeupB <= 1'($urandom);
            farLow <= 8'($urandom);
            farLowOe <= ~((m == 3) ? 8'h0C : 8'h15);
            farHigh <= 4'($urandom);
            mainI = m;
            repeat (4) @(posedge ref_clk);
            verify();
            foreach (codes[i]) send_code(codes[i]);
            $display("main mode %0d done", m);
        end
        finish_test();
    end
endmodule
